// ===== cma_top.sv
// Current channel post-processing with auto-zero and charge accumulation
//
// Functional notes
// - Current is (raw - offset - auto-zero offset) times gain, divided by 16384.
// - Readings whose magnitude is under the zero-zone limit read zero and are not accumulated.
// - The current channel carries 15 bits of magnitude plus sign.
// - One step is 9.15 mV over the shunt in milliohms; full scale is 16384 steps.
// - Current is signed, covering charge and discharge.
// - Corrected current is accumulated every measurement period on the clock time base.
// - With auto-zero enabled, an auto-zero cycle runs once every 30 seconds.
// - During auto-zero the shunt inputs are shorted and the zero-input offset is measured.
// - An auto-zero period skips the normal conversion and reuses the previous current.
// - The auto-zero offset is kept per chip and subtracted in the current computation.
// - The host writes offset and gain constants and the block uses the stored values.
//
// Register access over Wishbone and the register offsets were chosen for this implementation.
`include "cma_params.svh"

module cma_top #(
   parameter longint unsigned AZ_CYCLES   = `CMA_AZ_PERIOD_S * `CMA_CLK_HZ,
   parameter int unsigned     MEAS_PERIOD = `CMA_MEAS_PERIOD
) (
   input  wire logic               clk,           // 200 MHz clock
   input  wire logic               rst,           // Async reset, high
   input  wire logic               wb_cyc_i,      // Wishbone cycle
   input  wire logic               wb_stb_i,      // Wishbone strobe
   input  wire logic               wb_we_i,       // Wishbone write
   input  wire logic        [7:0]  wb_adr_i,      // Byte address
   input  wire logic        [31:0] wb_dat_i,      // Write data
   input  wire logic        [3:0]  wb_sel_i,      // Byte enables
   output logic             [31:0] wb_dat_o,      // Read data
   output logic                    wb_ack_o,      // Acknowledge
   input  wire logic               adc_valid,     // Converter result strobe
   input  wire logic signed [15:0] adc_data,      // Signed converter result
   output logic                    conv_start,    // Start of a period
   output logic                    shunt_short,   // Short shunt inputs
   output cma_pkg::cma_cur_t       current_ma,    // Corrected current
   output logic                    current_valid, // New current pulse
   output logic                    in_zero_zone,  // Current reads zero
   output logic signed      [47:0] capacity       // Accumulated charge
);

   localparam int AZ_W  = $clog2(AZ_CYCLES + 1);
   localparam int PER_W = $clog2(MEAS_PERIOD + 1);

   if (AZ_CYCLES < 2 || MEAS_PERIOD < 8 || AZ_CYCLES < 64'(MEAS_PERIOD)) begin : g_chk
      $error("cma_top: period parameters out of range");
   end

   // ---------------------------------------------------------------
   // Register state
   // ---------------------------------------------------------------
   logic                     az_enable;
   logic                     acc_clear;
   logic signed [15:0]       current_offset_corr;
   logic        [15:0]       current_gain_corr;
   logic signed [15:0]       autozero_offset;
   logic        [15:0]       zero_zone_limit;

   cma_pkg::cma_mode_t       mode;
   logic        [PER_W-1:0]  per_cnt;
   logic        [AZ_W-1:0]   az_cnt;
   logic                     az_due;
   logic                     got_sample;
   logic                     period_end;
   logic                     az_tick;
   logic                     take;
   logic                     corr_in_valid;
   logic                     az_capture;
   logic                     res_valid;
   cma_pkg::cma_cur_t        res_cur;
   logic                     res_zone;
   logic                     wb_req;
   logic                     wb_wr;
   logic signed [35:0]       az_meas;

   function automatic logic [15:0] wr16(input logic [15:0] old,
                                        input logic [31:0] d,
                                        input logic [3:0]  sel);
      logic [15:0] r;
      r = old;
      if (sel[0]) begin
         r[7:0] = d[7:0];
      end
      if (sel[1]) begin
         r[15:8] = d[15:8];
      end
      return r;
   endfunction

   // ---------------------------------------------------------------
   // Wishbone slave, one wait state
   // ---------------------------------------------------------------
   assign wb_req = wb_cyc_i && wb_stb_i && !wb_ack_o;
   assign wb_wr  = wb_req && wb_we_i;

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         wb_ack_o <= 1'b0;
      end else begin
         wb_ack_o <= wb_req;
      end
   end

   // Unmapped addresses acknowledge and read as zero
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         wb_dat_o <= '0;
      end else if (wb_req && !wb_we_i) begin
         case (wb_adr_i)
            `CMA_ADDR_CTRL:   wb_dat_o <= {31'h0, az_enable};
            `CMA_ADDR_STATUS: wb_dat_o <= {29'h0, az_due, in_zero_zone, shunt_short};
            `CMA_ADDR_COFS:   wb_dat_o <= {16'h0, current_offset_corr};
            `CMA_ADDR_GAIN:   wb_dat_o <= {16'h0, current_gain_corr};
            `CMA_ADDR_AZOFS:  wb_dat_o <= {16'h0, autozero_offset};
            `CMA_ADDR_ZONE:   wb_dat_o <= {16'h0, zero_zone_limit};
            `CMA_ADDR_CURR:   wb_dat_o <= {16'h0, current_ma};
            `CMA_ADDR_ACC_LO: wb_dat_o <= capacity[31:0];
            `CMA_ADDR_ACC_HI: wb_dat_o <= {16'h0, capacity[47:32]};
            default:          wb_dat_o <= '0;
         endcase
      end
   end

   // ---------------------------------------------------------------
   // Host-written configuration
   // ---------------------------------------------------------------
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         az_enable <= 1'b0;
         acc_clear <= 1'b0;
      end else begin
         acc_clear <= 1'b0;
         if (wb_wr && wb_adr_i == `CMA_ADDR_CTRL && wb_sel_i[0]) begin
            az_enable <= wb_dat_i[`CMA_CTRL_AZ_EN];
            acc_clear <= wb_dat_i[`CMA_CTRL_ACC_CLR];
         end
      end
   end

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         current_offset_corr <= `CMA_RST_OFS;
         current_gain_corr   <= `CMA_RST_GAIN;
         zero_zone_limit     <= `CMA_RST_ZONE;
      end else if (wb_wr) begin
         case (wb_adr_i)
            `CMA_ADDR_COFS: current_offset_corr <= wr16(current_offset_corr, wb_dat_i, wb_sel_i);
            `CMA_ADDR_GAIN: current_gain_corr <= wr16(current_gain_corr, wb_dat_i, wb_sel_i);
            `CMA_ADDR_ZONE: zero_zone_limit <= wr16(zero_zone_limit, wb_dat_i, wb_sel_i);
            default: ;
         endcase
      end
   end

   // Measured offset wins over a host write in the same cycle
   assign az_meas = 36'(adc_data) - 36'(current_offset_corr);

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         autozero_offset <= `CMA_RST_OFS;
      end else if (az_capture) begin
         autozero_offset <= cma_pkg::cma_sat16(az_meas);
      end else if (wb_wr && wb_adr_i == `CMA_ADDR_AZOFS) begin
         autozero_offset <= wr16(autozero_offset, wb_dat_i, wb_sel_i);
      end
   end

   // ---------------------------------------------------------------
   // Measurement period and auto-zero scheduling
   // ---------------------------------------------------------------
   assign period_end = (per_cnt == PER_W'(MEAS_PERIOD - 1));
   assign az_tick    = az_enable && (az_cnt == AZ_W'(AZ_CYCLES - 1));

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         per_cnt <= '0;
      end else begin
         per_cnt <= period_end ? '0 : per_cnt + 1'b1;
      end
   end

   // Held at zero while disabled so enabling restarts a full interval
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         az_cnt <= '0;
      end else if (!az_enable || az_tick) begin
         az_cnt <= '0;
      end else begin
         az_cnt <= az_cnt + 1'b1;
      end
   end

   // The due flag survives until a period boundary takes it or auto-zero is disabled; a new tick wins
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         az_due <= 1'b0;
      end else if (az_tick) begin
         az_due <= 1'b1;
      end else if (!az_enable || (period_end && az_due)) begin
         az_due <= 1'b0;
      end
   end

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         mode        <= cma_pkg::CMA_MODE_NORMAL;
         shunt_short <= 1'b0;
         conv_start  <= 1'b0;
      end else begin
         conv_start <= period_end;
         if (period_end) begin
            if (az_due && az_enable) begin
               mode        <= cma_pkg::CMA_MODE_AZ;
               shunt_short <= 1'b1;
            end else begin
               mode        <= cma_pkg::CMA_MODE_NORMAL;
               shunt_short <= 1'b0;
            end
         end
      end
   end

   // ---------------------------------------------------------------
   // Sample routing: first result of each period only
   // ---------------------------------------------------------------
   assign take          = adc_valid && !got_sample;
   assign corr_in_valid = take && (mode == cma_pkg::CMA_MODE_NORMAL);
   assign az_capture    = take && (mode == cma_pkg::CMA_MODE_AZ);

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         got_sample <= 1'b0;
      end else if (period_end) begin
         got_sample <= 1'b0;
      end else if (take) begin
         got_sample <= 1'b1;
      end
   end

   // Raw input is sign plus 15 magnitude bits; one count is one current step
   cma_corrector u_corr (
      .clk       (clk),
      .rst       (rst),
      .in_valid  (corr_in_valid),
      .in_raw    (adc_data),
      .in_cofs   (current_offset_corr),
      .in_azofs  (autozero_offset),
      .in_gain   (current_gain_corr),
      .in_zone   (zero_zone_limit),
      .res_valid (res_valid),
      .res_cur   (res_cur),
      .res_zone  (res_zone)
   );

   // Auto-zero periods leave these untouched, so the old value is reused
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         current_ma    <= '0;
         in_zero_zone  <= 1'b1;
         current_valid <= 1'b0;
      end else begin
         current_valid <= res_valid;
         if (res_valid) begin
            current_ma   <= res_cur;
            in_zero_zone <= res_zone;
         end
      end
   end

   // ---------------------------------------------------------------
   // Charge accumulation, one step per measurement period
   // ---------------------------------------------------------------
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         capacity <= '0;
      end else if (acc_clear) begin
         capacity <= '0;
      end else if (period_end && !in_zero_zone) begin
         capacity <= capacity + 48'(current_ma);
      end
   end

   // ---------------------------------------------------------------
   // Checks
   // ---------------------------------------------------------------
   default clocking cb @(posedge clk); endclocking
   default disable iff (rst);

   chk_ack_single: assert property (wb_ack_o |=> !wb_ack_o)
      else $error("ack held longer than one cycle");
   chk_ack_follows: assert property (wb_req |=> wb_ack_o)
      else $error("request not acknowledged next cycle");
   chk_gain_write: assert property (wb_wr && wb_adr_i == `CMA_ADDR_GAIN && wb_sel_i == 4'hf
                                    |=> current_gain_corr == $past(wb_dat_i[15:0]))
      else $error("gain write not stored");
   chk_az_enter: assert property (period_end && az_due && az_enable
                                  |=> shunt_short && mode == cma_pkg::CMA_MODE_AZ)
      else $error("auto-zero period not entered");
   chk_az_one_period: assert property ($changed(shunt_short) |-> $past(period_end))
      else $error("shunt short changed inside period");
   chk_az_skip_conv: assert property (shunt_short |-> !corr_in_valid)
      else $error("normal conversion in auto-zero period");
   chk_az_counter: assert property (az_cnt <= AZ_W'(AZ_CYCLES - 1))
      else $error("auto-zero interval overrun");
   chk_corr_latency: assert property (corr_in_valid |-> ##2 res_valid ##1 current_valid)
      else $error("correction latency wrong");
   chk_zone_zero: assert property (res_valid && res_zone |=> current_ma == 16'sh0000)
      else $error("zero-zone reading not zero");
   chk_zone_no_acc: assert property (period_end && in_zero_zone && !acc_clear
                                     |=> capacity == $past(capacity))
      else $error("zero-zone reading accumulated");
   chk_acc_add: assert property (period_end && !in_zero_zone && !acc_clear
                                 |=> capacity == $past(capacity) + 48'($past(current_ma)))
      else $error("capacity step wrong");
   chk_no_wrap: assert property (res_valid |-> res_cur != 16'sh8000)
      else $error("result not saturated");

endmodule

// ===== cma_params.svh
// Constants for the current measurement and auto-zero block
`ifndef CMA_PARAMS_SVH
`define CMA_PARAMS_SVH

// ---------------------------------------------------------------
// Time base
// ---------------------------------------------------------------
`define CMA_CLK_HZ        64'd200000000
`define CMA_AZ_PERIOD_S   64'd30
`define CMA_MEAS_PERIOD   32'd200000

// ---------------------------------------------------------------
// Arithmetic
// ---------------------------------------------------------------
`define CMA_GAIN_SHIFT    14
`define CMA_FULL_SCALE    32'd16384
`define CMA_STEP_UV       32'd9150
`define CMA_SAT_MAX       16'sh7fff
`define CMA_SAT_MIN       (-16'sh7fff)

// ---------------------------------------------------------------
// Register byte addresses
// ---------------------------------------------------------------
`define CMA_ADDR_CTRL     8'h00
`define CMA_ADDR_STATUS   8'h04
`define CMA_ADDR_COFS     8'h08
`define CMA_ADDR_GAIN     8'h0c
`define CMA_ADDR_AZOFS    8'h10
`define CMA_ADDR_ZONE     8'h14
`define CMA_ADDR_CURR     8'h18
`define CMA_ADDR_ACC_LO   8'h1c
`define CMA_ADDR_ACC_HI   8'h20

// ---------------------------------------------------------------
// Fields and reset values
// ---------------------------------------------------------------
`define CMA_CTRL_AZ_EN    0
`define CMA_CTRL_ACC_CLR  1
`define CMA_ST_AZ_ACTIVE  0
`define CMA_ST_IN_ZONE    1
`define CMA_ST_AZ_DUE     2
`define CMA_RST_GAIN      16'h4000
`define CMA_RST_ZONE      16'h0003
`define CMA_RST_OFS       16'h0000

`endif

// ===== cma_pkg.sv
// Types and shared arithmetic for the current measurement block
package cma_pkg;

   // Gray order: normal period, then auto-zero period
   typedef enum logic [1:0] {
      CMA_MODE_NORMAL = 2'b00,
      CMA_MODE_AZ     = 2'b01
   } cma_mode_t;

   typedef logic signed [15:0] cma_cur_t;

   // Symmetric saturation so that negation never overflows
   function automatic cma_cur_t cma_sat16(input logic signed [35:0] v);
      if (v > 36'sd32767) begin
         return 16'sh7fff;
      end else if (v < -36'sd32767) begin
         return -16'sh7fff;
      end else begin
         return v[15:0];
      end
   endfunction

endpackage

// ===== cma_corrector.sv
// Two-stage offset, gain and zero-zone correction of one raw sample
`include "cma_params.svh"

module cma_corrector (
   input  wire logic                clk,       // System clock
   input  wire logic                rst,       // Async reset, high
   input  wire logic                in_valid,  // Raw sample strobe
   input  wire logic signed [15:0]  in_raw,    // Raw signed result
   input  wire logic signed [15:0]  in_cofs,   // Stored offset
   input  wire logic signed [15:0]  in_azofs,  // Auto-zero offset
   input  wire logic        [15:0]  in_gain,   // Gain, unity 16384
   input  wire logic        [15:0]  in_zone,   // Zero-zone limit
   output logic                     res_valid, // Result strobe
   output cma_pkg::cma_cur_t        res_cur,   // Corrected current
   output logic                     res_zone   // Result was zeroed
);

   logic                signed [17:0] diff;
   logic                              s1_valid;
   logic                       [15:0] s1_gain;
   logic                       [15:0] s1_zone;
   logic                signed [35:0] prod;
   logic                signed [35:0] scaled;
   cma_pkg::cma_cur_t                 sat;
   logic                       [15:0] mag;

   // ---------------------------------------------------------------
   // Stage 1: offset subtraction, 18 bits so it cannot wrap
   // ---------------------------------------------------------------
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         diff     <= '0;
         s1_valid <= 1'b0;
         s1_gain  <= `CMA_RST_GAIN;
         s1_zone  <= `CMA_RST_ZONE;
      end else begin
         s1_valid <= in_valid;
         if (in_valid) begin
            diff    <= 18'(in_raw) - 18'(in_cofs) - 18'(in_azofs);
            s1_gain <= in_gain;
            s1_zone <= in_zone;
         end
      end
   end

   // ---------------------------------------------------------------
   // Stage 2: gain, divide by 16384, saturate, zero zone
   // ---------------------------------------------------------------
   always_comb begin
      prod   = 36'(diff) * 36'(signed'({1'b0, s1_gain}));
      scaled = prod >>> `CMA_GAIN_SHIFT;
      sat    = cma_pkg::cma_sat16(scaled);
      mag    = sat[15] ? 16'(-sat) : 16'(sat);
   end

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         res_valid <= 1'b0;
         res_cur   <= '0;
         res_zone  <= 1'b0;
      end else begin
         res_valid <= s1_valid;
         if (s1_valid) begin
            res_zone <= (mag < s1_zone);
            res_cur  <= (mag < s1_zone) ? 16'sh0000 : sat;
         end
      end
   end

endmodule

// ===== cma_adc_model.sv
// Behavioural converter front end answering each period start
module cma_adc_model (
   input  wire logic               clk,     // System clock
   input  wire logic               rst,     // Async reset, high
   input  wire logic               start,   // Period start pulse
   input  wire logic               shorted, // Shunt inputs shorted
   input  wire logic signed [15:0] raw,     // Value across the shunt
   input  wire logic signed [15:0] zofs,    // Value seen when shorted
   input  wire logic        [3:0]  lat,     // Conversion delay in cycles
   output logic                    vld,     // Result strobe
   output logic signed      [15:0] dat      // Result
);
   timeunit 1ns;
   timeprecision 1ps;
   logic [4:0] cnt;
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         cnt <= 5'h00;
         vld <= 1'b0;
         dat <= 16'h0000;
      end else begin
         if (start) begin
            cnt <= {1'b0, lat} + 5'h01;
         end else if (cnt != 5'h00) begin
            cnt <= cnt - 5'h01;
         end
         vld <= (cnt == 5'h01);
         if (cnt == 5'h01) begin
            dat <= shorted ? zofs : raw;
         end else begin
            // Result no longer held: scramble so stale data is never reused
            dat <= ~dat;
         end
      end
   end
endmodule

// ===== tb_cma_top.sv
// Self-checking bench for the current channel post-processing block
`include "cma_params.svh"

module tb_cma_top;
   timeunit 1ns;
   timeprecision 1ps;
   localparam int     MP = 100;
   localparam longint AZ = 2000;
   typedef struct {
      logic signed [15:0] raw;
      logic signed [15:0] cofs;
      logic        [15:0] gain;
      logic        [15:0] zone;
      logic signed [15:0] cur;
      logic               z;
   } cma_row_t;
   cma_row_t rows [8] = '{
      '{16'h0064, 16'h0000, 16'h4000, 16'h0003, 16'h0064, 1'b0},
      '{16'h0064, 16'h000a, 16'h8000, 16'h0003, 16'h00b4, 1'b0},
      '{16'hffce, 16'h0000, 16'h4000, 16'h0003, 16'hffce, 1'b0},
      '{16'h0002, 16'h0000, 16'h4000, 16'h0003, 16'h0000, 1'b1},
      '{16'h0003, 16'h0000, 16'h4000, 16'h0003, 16'h0003, 1'b0},
      '{16'h0009, 16'h0000, 16'h4000, 16'h000a, 16'h0000, 1'b1},
      '{16'h7fff, 16'hff9c, 16'h8000, 16'h0003, 16'h7fff, 1'b0},
      '{16'h8000, 16'h0064, 16'hffff, 16'h0003, 16'h8001, 1'b0}};
   logic [7:0]  ra [6] = '{8'h00, 8'h08, 8'h0c, 8'h10, 8'h14, 8'h3c};
   logic [15:0] rv [6] = '{16'h0000, 16'h0000, 16'h4000, 16'h0000, 16'h0003, 16'h0000};
   logic               clk, rst, cyc, stb, we, ack, adc_valid, conv_start;
   logic               shunt_short, current_valid, in_zero_zone;
   logic        [7:0]  adr;
   logic        [31:0] wdat, rdat, q;
   logic        [3:0]  sel, lat;
   logic signed [15:0] adc_data, current_ma, raw, zofs;
   logic signed [47:0] capacity, c0;
   int                 fail_count, checked, n, m, v, tick;

   cma_top #(.AZ_CYCLES(AZ), .MEAS_PERIOD(MP)) dut_u (
      .clk(clk), .rst(rst), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we),
      .wb_adr_i(adr), .wb_dat_i(wdat), .wb_sel_i(sel), .wb_dat_o(rdat),
      .wb_ack_o(ack), .adc_valid(adc_valid), .adc_data(adc_data),
      .conv_start(conv_start), .shunt_short(shunt_short), .current_ma(current_ma),
      .current_valid(current_valid), .in_zero_zone(in_zero_zone), .capacity(capacity));

   cma_adc_model adc_u (
      .clk(clk), .rst(rst), .start(conv_start), .shorted(shunt_short), .raw(raw),
      .zofs(zofs), .lat(lat), .vld(adc_valid), .dat(adc_data));

   // ----------------------------------------
   // Shared tasks
   // ----------------------------------------
   task automatic stop_test;
      $display("checks %0d mismatches %0d", checked, fail_count);
      if (fail_count == 0 && checked > 0) begin
         $display("SIMULATION PASSED");
      end else begin
         $display("SIMULATION FAILED");
      end
      $finish;
   endtask

   task automatic chk(input string s, input logic [47:0] seen, input logic [47:0] exp);
      checked++;
      if (seen !== exp) begin
         fail_count++;
         $display("unexpected %s expected %h seen %h", s, exp, seen);
      end
   endtask

   // Classic single cycle; the request stands until ack is sampled high
   task automatic wb(input logic w, input logic [7:0] a, input logic [15:0] d);
      int k;
      @(posedge clk);
      cyc <= 1'b1;
      stb <= 1'b1;
      we <= w;
      adr <= a;
      wdat <= {16'h0000, d};
      sel <= 4'hf;
      k = 0;
      do begin
         @(posedge clk);
         k++;
      end while (ack !== 1'b1 && k < 50);
      if (ack !== 1'b1) begin
         fail_count++;
      end
      q = rdat;
      cyc <= 1'b0;
      stb <= 1'b0;
      we <= 1'b0;
   endtask

   // Wait for k pulses of current_valid (s 0) or conv_start (s 1)
   task automatic wt(input int s, input int k);
      int t;
      t = 0;
      while (k > 0 && t < 3000) begin
         @(posedge clk);
         t++;
         if ((s == 0 ? current_valid : conv_start) === 1'b1) k--;
      end
      if (k > 0) begin
         fail_count++;
      end
   endtask

   initial begin
      clk = 1'b0;
      forever #2.5 clk = ~clk;
   end

   // Free-running edge count, so waits inside tasks still count
   always_ff @(posedge clk) begin
      tick <= tick + 1;
   end

   initial begin
      repeat (20000) @(posedge clk);
      fail_count++;
      stop_test();
   end

   // ----------------------------------------
   // Main sequence
   // ----------------------------------------
   initial begin
      {rst, cyc, stb, we, adr, wdat, sel} = {1'b1, 47'h0};
      {raw, zofs, lat, fail_count, checked} = '0;
      repeat (2) @(posedge clk);
      rst <= 1'b0;
      @(posedge clk);
      chk("reset zone", in_zero_zone, 1'b1);
      chk("reset capacity", capacity, 48'h0);
      chk("reset short", shunt_short, 1'b0);
      foreach (ra[i]) begin
         wb(1'b0, ra[i], 16'h0000);
         chk("register reset", q, {16'h0000, rv[i]});
      end
      foreach (rows[i]) begin
         lat <= i[3:0];
         raw <= rows[i].raw;
         wb(1'b1, `CMA_ADDR_COFS, rows[i].cofs);
         wb(1'b1, `CMA_ADDR_GAIN, rows[i].gain);
         wb(1'b1, `CMA_ADDR_ZONE, rows[i].zone);
         wt(0, 2);
         chk("current", current_ma, rows[i].cur);
         chk("zone flag", in_zero_zone, rows[i].z);
         wb(1'b0, `CMA_ADDR_CURR, 16'h0000);
         chk("current reg", q, {16'h0000, rows[i].cur});
      end
      // Accumulation of a steady 100 mA, after a clear
      raw <= 16'h0064;
      zofs <= 16'h0028;
      wb(1'b1, `CMA_ADDR_COFS, 16'h0000);
      wb(1'b1, `CMA_ADDR_GAIN, 16'h4000);
      wb(1'b1, `CMA_ADDR_ZONE, 16'h0003);
      wt(0, 2);
      wb(1'b1, `CMA_ADDR_CTRL, 16'h0003);
      @(posedge clk);
      // Edge count at which the enable landed, two edges back
      n = tick - 2;
      chk("cleared", capacity, 48'h0);
      wt(1, 1);
      c0 = capacity;
      wt(1, 1);
      chk("capacity step", capacity - c0, 48'h64);
      // Auto-zero: shorted period, no conversion, previous current reused
      while (shunt_short !== 1'b1 && tick - n < 3000) begin
         @(posedge clk);
      end
      n = tick - n;
      chk("az interval", (n >= AZ && n <= AZ + MP + 2), 1'b1);
      chk("az with start", conv_start, 1'b1);
      c0 = capacity;
      {m, v} = '0;
      while (shunt_short === 1'b1 && m < 300) begin
         @(posedge clk);
         m++;
         v += current_valid;
      end
      chk("short length", m, MP);
      chk("az conversions", v, 0);
      chk("az reuse", capacity - c0, 48'h64);
      wb(1'b0, `CMA_ADDR_AZOFS, 16'h0000);
      chk("az offset", q, 32'h28);
      wt(0, 1);
      chk("after az", current_ma, 16'h003c);
      wb(1'b1, `CMA_ADDR_CTRL, 16'h0000);
      // In-zone current stays out of the accumulator
      raw <= 16'h002a;
      wt(0, 2);
      wt(1, 1);
      c0 = capacity;
      wt(1, 1);
      chk("zone excluded", capacity - c0, 48'h0);
      wb(1'b0, `CMA_ADDR_STATUS, 16'h0000);
      chk("status", q, 32'h2);
      wb(1'b0, `CMA_ADDR_ACC_LO, 16'h0000);
      chk("capacity low", q, c0[31:0]);
      wb(1'b0, `CMA_ADDR_ACC_HI, 16'h0000);
      chk("capacity high", q, {16'h0000, c0[47:32]});
      // Mid-run reset must bring back the power-up state
      rst <= 1'b1;
      @(posedge clk);
      rst <= 1'b0;
      @(posedge clk);
      chk("rerun capacity", capacity, 48'h0);
      chk("rerun current", current_ma, 16'h0000);
      chk("rerun zone", in_zero_zone, 1'b1);
      wb(1'b0, `CMA_ADDR_AZOFS, 16'h0000);
      chk("rerun az offset", q, 32'h0);
      stop_test();
   end
endmodule
